//--- verilog/qitb_top.sv
// Purpose: four interval timers with control, load, count and clear registers
// Assumes: one request per cycle on the register port, single clock domain
// Notes: read answers arrive one cycle after the request
`timescale 1ns/1ps

module qitb_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire qitb_pkg::qitb_req_t req,
  output qitb_pkg::qitb_rsp_t rsp,
  // interrupt
  output logic irq
);

  localparam int unsigned NT = qitb_pkg::NUM_TIMERS;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] latch_mode;
    logic [NT-1:0][31:0] load;
    logic [NT-1:0][31:0] latched;
    logic [NT-1:0] load_stb;
    qitb_pkg::qitb_rsp_t rsp;
    logic irq;
  } qitb_top_st_t;

  qitb_top_st_t st_ff;
  qitb_top_st_t nxt_st;

  logic [qitb_pkg::RATE_STEPS-1:0] rate_tick;
  logic [NT-1:0][31:0] live;
  logic [NT-1:0] tc;
  logic [NT-1:0] tmr_tick;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic int unsigned bit_of(input int unsigned t, input int unsigned pos);
    bit_of = t * qitb_pkg::CTRL_STRIDE + pos;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic [1:0] rate_of(input logic [31:0] c, input int unsigned t);
    rate_of = c[bit_of(t, qitb_pkg::POS_RATE) +: 2];
  endfunction

  // ****************************************************************
  // tick generation and timers
  // ****************************************************************
  qitb_prescale #(
    .DIV(qitb_pkg::BASE_DIV)
  ) u_prescale (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(rate_tick)
  );

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    // first pair short, second pair long
    localparam int unsigned W = (i < qitb_pkg::NUM_SHORT) ? qitb_pkg::SHORT_W : qitb_pkg::LONG_W;
    logic [W-1:0] cnt;
    assign tmr_tick[i] = rate_tick[rate_of(st_ff.ctrl, i)];
    qitb_timer #(
      .W(W)
    ) u_timer (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(tmr_tick[i]),
      .enable(st_ff.ctrl[bit_of(i, qitb_pkg::POS_ENABLE)]),
      .load_stb(st_ff.load_stb[i]),
      .load_val(st_ff.load[i][W-1:0]),
      .count(cnt),
      .tc(tc[i])
    );
    assign live[i] = 32'(cnt);
  end

  // ****************************************************************
  // register access and flags
  // ****************************************************************
  always_comb begin
    logic all_mode;
    logic [31:0] wctrl;
    logic [31:0] wpair;
    all_mode = 1'b0;
    wctrl = 32'h0000_0000;
    wpair = 32'h0000_0000;
    nxt_st = st_ff;
    nxt_st.load_stb = '0;
    nxt_st.rsp = '0;
    all_mode = st_ff.latch_mode[qitb_pkg::POS_LATCH_ALL];

    if (req.wr) begin
      unique case (req.addr)
        qitb_pkg::OFS_CTRL: begin
          wctrl = merge(st_ff.ctrl, req.wdata, req.be);
          // cause flags can only be cleared by software, never set
          for (int t = 0; t < NT; t++) begin
            wctrl[bit_of(t, qitb_pkg::POS_CAUSE)] = st_ff.ctrl[bit_of(t, qitb_pkg::POS_CAUSE)] &
              wctrl[bit_of(t, qitb_pkg::POS_CAUSE)];
          end
          nxt_st.ctrl = wctrl;
        end
        qitb_pkg::OFS_LATCH_MODE: begin
          nxt_st.latch_mode = merge(st_ff.latch_mode, req.wdata, req.be);
        end
        qitb_pkg::OFS_LOAD_PAIR: begin
          // the two halves live in one word; each half strobes its own timer
          wpair = merge({st_ff.load[1][15:0], st_ff.load[0][15:0]}, req.wdata, req.be);
          nxt_st.load[0] = {16'h0000, wpair[15:0]};
          nxt_st.load[1] = {16'h0000, wpair[31:16]};
          nxt_st.load_stb[0] = |req.be[1:0];
          nxt_st.load_stb[1] = |req.be[3:2];
        end
        qitb_pkg::OFS_LOAD_THIRD: begin
          nxt_st.load[2] = merge(st_ff.load[2], req.wdata, req.be);
          nxt_st.load_stb[2] = |req.be;
        end
        qitb_pkg::OFS_LOAD_FOURTH: begin
          nxt_st.load[3] = merge(st_ff.load[3], req.wdata, req.be);
          nxt_st.load_stb[3] = |req.be;
        end
        qitb_pkg::OFS_CLR_FIRST: begin
          nxt_st.ctrl[bit_of(0, qitb_pkg::POS_CAUSE)] = 1'b0;
        end
        qitb_pkg::OFS_CLR_SECOND: begin
          nxt_st.ctrl[bit_of(1, qitb_pkg::POS_CAUSE)] = 1'b0;
        end
        qitb_pkg::OFS_CLR_THIRD: begin
          nxt_st.ctrl[bit_of(2, qitb_pkg::POS_CAUSE)] = 1'b0;
        end
        qitb_pkg::OFS_CLR_FOURTH: begin
          nxt_st.ctrl[bit_of(3, qitb_pkg::POS_CAUSE)] = 1'b0;
        end
        // count registers ignore writes, unmapped writes vanish
        default: begin
        end
      endcase
    end

    if (req.rd) begin
      nxt_st.rsp.valid = 1'b1;
      unique case (req.addr)
        qitb_pkg::OFS_CTRL: begin
          nxt_st.rsp.data = st_ff.ctrl;
        end
        qitb_pkg::OFS_LATCH_MODE: begin
          nxt_st.rsp.data = st_ff.latch_mode;
        end
        qitb_pkg::OFS_LOAD_PAIR: begin
          nxt_st.rsp.data = {st_ff.load[1][15:0], st_ff.load[0][15:0]};
        end
        qitb_pkg::OFS_LOAD_THIRD: begin
          nxt_st.rsp.data = st_ff.load[2];
        end
        qitb_pkg::OFS_LOAD_FOURTH: begin
          nxt_st.rsp.data = st_ff.load[3];
        end
        qitb_pkg::OFS_CUR_PAIR: begin
          nxt_st.latched[0] = live[0];
          nxt_st.latched[1] = live[1];
          if (all_mode) begin
            nxt_st.latched[2] = live[2];
            nxt_st.latched[3] = live[3];
          end
          nxt_st.rsp.data = {live[1][15:0], live[0][15:0]};
        end
        qitb_pkg::OFS_CUR_THIRD: begin
          if (all_mode) begin
            nxt_st.rsp.data = st_ff.latched[2];
          end else begin
            nxt_st.latched[2] = live[2];
            nxt_st.rsp.data = live[2];
          end
        end
        qitb_pkg::OFS_CUR_FOURTH: begin
          if (all_mode) begin
            nxt_st.rsp.data = st_ff.latched[3];
          end else begin
            nxt_st.latched[3] = live[3];
            nxt_st.rsp.data = live[3];
          end
        end
        // clear registers are write only and read back as zero
        default: begin
          nxt_st.rsp.data = 32'h0000_0000;
        end
      endcase
    end

    // applied after software clears, so a timeout in the clearing cycle survives
    for (int t = 0; t < NT; t++) begin
      if (tc[t] & st_ff.ctrl[bit_of(t, qitb_pkg::POS_IRQ_EN)]) begin
        nxt_st.ctrl[bit_of(t, qitb_pkg::POS_CAUSE)] = 1'b1;
      end
    end

    nxt_st.irq = 1'b0;
    for (int t = 0; t < NT; t++) begin
      nxt_st.irq = nxt_st.irq | (nxt_st.ctrl[bit_of(t, qitb_pkg::POS_CAUSE)] &
                                 nxt_st.ctrl[bit_of(t, qitb_pkg::POS_IRQ_EN)]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.ctrl <= qitb_pkg::RST_CTRL;
      st_ff.latch_mode <= qitb_pkg::RST_LATCH_MODE;
      st_ff.load <= {NT{qitb_pkg::RST_LOAD}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp = st_ff.rsp;
  assign irq = st_ff.irq;

endmodule // qitb_top

//--- include/qitb_pkg.sv
// Purpose: shared constants and carrier types of the quad interval timer bank
// Assumes: 50 MHz system clock, byte-addressed register window with 32-bit data
// Notes: offsets are byte addresses inside the timer window
package qitb_pkg;

  // ****************************************************************
  // clocking
  // ****************************************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BASE_TICK_HZ = 2_000_000;
  localparam int unsigned BASE_DIV = CLK_HZ / BASE_TICK_HZ;
  localparam int unsigned RATE_STEPS = 4;

  // ****************************************************************
  // timer geometry
  // ****************************************************************
  localparam int unsigned NUM_TIMERS = 4;
  localparam int unsigned SHORT_W = 16;
  localparam int unsigned LONG_W = 32;
  localparam int unsigned NUM_SHORT = 2;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LATCH_MODE = 8'h04;
  localparam logic [7:0] OFS_LOAD_PAIR = 8'h10;
  localparam logic [7:0] OFS_LOAD_THIRD = 8'h14;
  localparam logic [7:0] OFS_LOAD_FOURTH = 8'h18;
  localparam logic [7:0] OFS_CUR_PAIR = 8'h20;
  localparam logic [7:0] OFS_CUR_THIRD = 8'h24;
  localparam logic [7:0] OFS_CUR_FOURTH = 8'h28;
  localparam logic [7:0] OFS_CLR_FIRST = 8'h30;
  localparam logic [7:0] OFS_CLR_SECOND = 8'h34;
  localparam logic [7:0] OFS_CLR_THIRD = 8'h38;
  localparam logic [7:0] OFS_CLR_FOURTH = 8'h3c;

  // ****************************************************************
  // control field layout, one byte per timer
  // ****************************************************************
  localparam int unsigned CTRL_STRIDE = 8;
  localparam int unsigned POS_CAUSE = 0;
  localparam int unsigned POS_ENABLE = 1;
  localparam int unsigned POS_IRQ_EN = 2;
  localparam int unsigned POS_RATE = 3;
  localparam int unsigned POS_LATCH_ALL = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_LATCH_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_LOAD = 32'h0000_0000;

  // ****************************************************************
  // register port carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } qitb_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } qitb_rsp_t;

endpackage

//--- verilog/qitb_prescale.sv
// Purpose: rate tick generator for the timer bank
// Assumes: system clock an integer multiple of the base tick rate
// Notes: tick[k] pulses one cycle at base rate divided by 2**k
`timescale 1ns/1ps
module qitb_prescale #(
  parameter int unsigned DIV = qitb_pkg::BASE_DIV
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // rate ticks
  output logic [qitb_pkg::RATE_STEPS-1:0] tick
);

  typedef struct packed {
    logic [7:0] base_cnt;
    logic [qitb_pkg::RATE_STEPS-2:0] div;
    logic [qitb_pkg::RATE_STEPS-1:0] tick;
  } qitb_pre_st_t;

  qitb_pre_st_t st_ff;
  qitb_pre_st_t nxt_st;

  always_comb begin
    logic wrap;
    logic [7:0] low_mask;
    wrap = 1'b0;
    low_mask = 8'h00;
    nxt_st = st_ff;
    nxt_st.tick = '0;
    wrap = (st_ff.base_cnt == 8'(DIV - 1));
    if (wrap) begin
      nxt_st.base_cnt = 8'h00;
      nxt_st.div = st_ff.div + 1'b1;
    end else begin
      nxt_st.base_cnt = st_ff.base_cnt + 8'h01;
    end
    // all slower ticks coincide with a base tick, so rates stay phase aligned
    nxt_st.tick[0] = wrap;
    for (int k = 1; k < qitb_pkg::RATE_STEPS; k++) begin
      // mask instead of a variable part-select of the divider
      low_mask = 8'((1 << k) - 1);
      nxt_st.tick[k] = wrap & ((8'(st_ff.div) & low_mask) == low_mask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule // qitb_prescale

//--- verilog/qitb_timer.sv
// Purpose: one down-counting interval timer with auto reload
// Assumes: tick is a one-cycle pulse marking the timer clock rising edge
// Notes: a load request waits for the next tick, enabled or not
`timescale 1ns/1ps
module qitb_timer #(
  parameter int unsigned W = qitb_pkg::LONG_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic tick,
  input wire logic enable,
  input wire logic load_stb,
  input wire logic [W-1:0] load_val,
  // status
  output logic [W-1:0] count,
  output logic tc
);

  typedef struct packed {
    logic [W-1:0] count;
    logic pend;
    logic tc;
  } qitb_tmr_st_t;

  qitb_tmr_st_t st_ff;
  qitb_tmr_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tc = 1'b0;
    if (load_stb) begin
      nxt_st.pend = 1'b1;
    end
    if (tick) begin
      if (st_ff.pend | load_stb) begin
        nxt_st.count = load_val;
        nxt_st.pend = 1'b0;
      end else if (enable) begin
        // a count of one or less reloads on the tick instead of stepping to zero, so the period equals the load value
        if (st_ff.count <= W'(1)) begin
          nxt_st.count = load_val;
          nxt_st.tc = 1'b1;
        end else begin
          nxt_st.count = st_ff.count - W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.count;
  assign tc = st_ff.tc;

endmodule // qitb_timer

//--- test/qitb_sva.sv
// Purpose: port-level checker of the timer bank register port and interrupt
// Assumes: read answers one cycle after the request, level interrupt
// Notes: bound to qitb_top at the foot of this file
`timescale 1ns/1ps
module qitb_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire qitb_pkg::qitb_req_t req,
  input wire qitb_pkg::qitb_rsp_t rsp,
  // interrupt
  input wire logic irq
);
  // ****************************************************************
  // helper: address of the read being answered
  // ****************************************************************
  logic [7:0] rd_addr_ff;
  logic [7:0] nxt_rd_addr;
  always_comb nxt_rd_addr = req.rd ? req.addr : rd_addr_ff;
  always_ff @(posedge clk_sys) rd_addr_ff <= nxt_rd_addr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_RD_ANSWER: assert property (req.rd |=> rsp.valid)
    else $error("read not answered one cycle later");
  AST_NO_STRAY_ANSWER: assert property (!req.rd |=> !rsp.valid)
    else $error("answer without a read");
  AST_IDLE_DATA: assert property (!rsp.valid |-> rsp.data == 32'h0000_0000)
    else $error("read data not zero outside an answer");
  AST_RESET_QUIET: assert property ($fell(reset) |-> !irq && !rsp.valid)
    else $error("outputs active after reset");
  AST_CLR_REG_READS_ZERO: assert property (req.rd && req.addr[7:4] == 4'h3 |=> rsp.data == 32'h0000_0000)
    else $error("clear register read not zero");
  AST_CTRL_ZERO_DROPS_IRQ: assert property (req.wr && req.addr == qitb_pkg::OFS_CTRL && req.be == 4'hf
    && req.wdata == 32'h0000_0000 |=> !irq)
    else $error("interrupt held after control cleared");
  AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |-> $past(req.wr) || $past(req.wr, 2))
    else $error("interrupt dropped without a write");
  AST_IRQ_MATCHES_FLAGS: assert property (rsp.valid && rd_addr_ff == qitb_pkg::OFS_CTRL |->
    $past(irq) == ((rsp.data[0] & rsp.data[2]) | (rsp.data[8] & rsp.data[10])
    | (rsp.data[16] & rsp.data[18]) | (rsp.data[24] & rsp.data[26])))
    else $error("interrupt disagrees with cause flags");
endmodule // qitb_sva

bind qitb_top qitb_sva u_sva (.clk_sys(clk_sys), .reset(reset), .req(req), .rsp(rsp), .irq(irq));

//--- test/qitb_host.sv
// Purpose: host software model driving the timer bank register port
// Assumes: one access at a time, request held one cycle
// Notes: released address, byte-enable and data lines show inverted values, never the last ones
`timescale 1ns/1ps
module qitb_host (
  // clock
  input wire logic clk_sys,
  // register port
  output qitb_pkg::qitb_req_t req,
  input wire qitb_pkg::qitb_rsp_t rsp
);
  initial req = '0;

  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge clk_sys);
    #1;
    req.wr = wr;
    req.rd = !wr;
    req.addr = addr;
    req.be = be;
    req.wdata = wdata;
    @(posedge clk_sys);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~addr;
    req.be = ~be;
    req.wdata = ~wdata;
    // missing answer turns into unknown so the bench sees it
    rdata = rsp.valid ? rsp.data : 'x;
  endtask

  // dedicated clear keeps the other control bits untouched
  task automatic clear_irq(input int k);
    logic [31:0] d;
    access(1'b1, 8'h30 + 8'(4 * k), 4'h0, 32'h5a5a_a5a5, d);
  endtask
endmodule // qitb_host

//--- test/qitb_top_tb_top.sv
// Purpose: self-checking bench of the timer bank
// Assumes: default prescaler, base tick every 25 clocks
// Notes: timer three with load 3 drives the interrupt scenarios
`timescale 1ns/1ps
module qitb_top_tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] exp_val;
  } qitb_row_t;
  localparam qitb_row_t ROWS [11] = '{
    '{8'h10, 4'h3, 32'h1234_5678, 32'h0000_5678}, '{8'h10, 4'hc, 32'habcd_0000, 32'habcd_5678},
    '{8'h14, 4'hf, 32'h0000_0003, 32'h0000_0003}, '{8'h18, 4'hf, 32'h1234_5678, 32'h1234_5678},
    '{8'h20, 4'hf, 32'hffff_ffff, 32'habcd_5678}, '{8'h24, 4'hf, 32'hffff_ffff, 32'h0000_0003},
    '{8'h28, 4'hf, 32'h0000_0000, 32'h1234_5678}, '{8'h30, 4'hf, 32'hffff_ffff, 32'h0000_0000},
    '{8'h2c, 4'hf, 32'hffff_ffff, 32'h0000_0000}, '{8'h04, 4'hf, 32'hffff_fff0, 32'hffff_fff0},
    '{8'h04, 4'hf, 32'h0000_0000, 32'h0000_0000}};
  logic clk_sys;
  logic reset;
  qitb_pkg::qitb_req_t req;
  qitb_pkg::qitb_rsp_t rsp;
  logic irq;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int t_rise;
  int t0;
  logic [31:0] d;
  logic [31:0] d1;

  qitb_top dut (.clk_sys(clk_sys), .reset(reset), .req(req), .rsp(rsp), .irq(irq));
  qitb_host host (.clk_sys(clk_sys), .req(req), .rsp(rsp));

  task automatic final_report;
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait; a miss shows up in the following compare
  task automatic wait_rise(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    t_rise = cycles;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    // look after the edge so registered outputs have settled
    #1;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    reset = 1'b1;
    settle(4);
    #1;
    reset = 1'b0;
    host.access(1'b0, 8'h00, 4'hf, 32'h0, d);
    check(d, 32'h0000_0000);
    host.access(1'b0, 8'h04, 4'hf, 32'h0, d);
    check(d, 32'h0000_0000);
    foreach (ROWS[i]) begin
      host.access(1'b1, ROWS[i].addr, ROWS[i].be, ROWS[i].wdata, d);
      settle(30);
      host.access(1'b0, ROWS[i].addr, 4'hf, 32'h0, d);
      check(d, ROWS[i].exp_val);
    end
    // every rate: gap between two timeouts of a three-tick period
    for (int k = 0; k < 4; k++) begin
      host.access(1'b1, 8'h00, 4'h4, {8'h00, 3'b000, k[1:0], 3'b110, 16'h0000}, d);
      wait_rise(1000);
      t0 = t_rise;
      host.clear_irq(2);
      settle(1);
      check({31'h0, irq}, 32'h0);
      wait_rise(1000);
      check(t_rise - t0, 75 << k);
      host.clear_irq(2);
    end
    wait_rise(1000);
    host.access(1'b0, 8'h00, 4'hf, 32'h0, d);
    check(d, 32'h001f_0000);
    host.access(1'b1, 8'h00, 4'h4, 32'h001e_0000, d);
    settle(1);
    check({31'h0, irq}, 32'h0);
    // timeouts without irq enable must stay silent
    host.access(1'b1, 8'h00, 4'h4, 32'h0002_0000, d);
    settle(300);
    check({31'h0, irq}, 32'h0);
    host.access(1'b0, 8'h00, 4'hf, 32'h0, d);
    check(d, 32'h0002_0000);
    host.access(1'b1, 8'h04, 4'hf, 32'h0000_0001, d);
    host.access(1'b0, 8'h20, 4'hf, 32'h0, d);
    settle(30);
    host.access(1'b0, 8'h24, 4'hf, 32'h0, d1);
    settle(30);
    host.access(1'b0, 8'h24, 4'hf, 32'h0, d);
    check(d, d1);
    host.access(1'b1, 8'h04, 4'hf, 32'h0000_0000, d);
    host.access(1'b0, 8'h24, 4'hf, 32'h0, d1);
    settle(30);
    host.access(1'b0, 8'h24, 4'hf, 32'h0, d);
    check({31'h0, d === d1}, 32'h0);
    // second reset in mid-run
    @(posedge clk_sys);
    #1;
    reset = 1'b1;
    settle(4);
    #1;
    reset = 1'b0;
    host.access(1'b0, 8'h00, 4'hf, 32'h0, d);
    check(d, 32'h0000_0000);
    check({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule // qitb_top_tb_top
